/* inc/sird_pkg.sv */
// Shared constants and carrier types of the serial interrupt and rate divider block
`default_nettype none

package sird_pkg;

	// ************************************************************
	// Register map
	// ************************************************************
	localparam int          ADDR_W            = 12;
	localparam logic [11:0] OFS_STATUS        = 12'h408;
	localparam logic [11:0] OFS_ENABLE_SET    = 12'h40C;
	localparam logic [11:0] OFS_ENABLE_CLEAR  = 12'h410;
	localparam logic [11:0] OFS_PRESCALE      = 12'h424;
	localparam logic [11:0] OFS_MASKED        = 12'h428;

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int          BIT_SEL_ASSERT    = 4;
	localparam int          BIT_SEL_RELEASE   = 5;
	localparam int          BIT_MASTER_QUIET  = 8;
	localparam int          PRESCALE_W        = 16;
	localparam logic [31:0] IMPL_MASK         = 32'h0000_0130;

	// ************************************************************
	// Values after reset
	// ************************************************************
	localparam logic [31:0] ENABLE_RST        = 32'h0000_0000;
	localparam logic [15:0] PRESCALE_RST      = 16'h0000;
	localparam logic        EVENT_FLAG_RST    = 1'h0;
	localparam logic        QUIET_FLAG_RST    = 1'h1;
	localparam logic [31:0] RDATA_RST         = 32'h0000_0000;

	// ************************************************************
	// Carrier types
	// ************************************************************
	// One register bus request, all fields sampled in the same cycle
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [31:0]       wdata;
		logic              wr_stb;
		logic              rd_stb;
	} sird_bus_req_type;

	// State reported by the serial engine on the same clock
	typedef struct packed {
		logic master_mode;
		logic tx_hold_empty;
		logic tx_busy;
	} sird_engine_type;

endpackage

`default_nettype wire

/* verilog/sird_rate_div.sv */
// Master serial clock rate divider producing a one-cycle enable
`timescale 1ns/1ps
`default_nettype none

module sird_rate_div #(
	parameter int DIV_W = 16
) (
	input  wire logic             ref_clk,
	input  wire logic             rst,
	input  wire logic             run,
	input  wire logic [DIV_W-1:0] div_value,
	output var  logic             tick
);

	logic [DIV_W-1:0] count_reg;
	logic [DIV_W-1:0] count_next;
	logic             tick_reg;
	logic             tick_next;

	// ************************************************************
	// Counter
	// ************************************************************
	// Count 0..div_value, one tick per wrap gives a period of value plus one
	always_comb begin
		count_next = count_reg;
		tick_next  = 1'h0;
		if (!run) begin
			count_next = '0; // Held quiet outside master mode
		end else if (count_reg >= div_value) begin
			count_next = '0; // Lowered value mid-count recovers at once
			tick_next  = 1'h1;
		end else begin
			count_next = count_reg + DIV_W'(1);
		end
	end

	// Register the counter and the tick
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			count_reg <= '0;
			tick_reg  <= 1'h0;
		end else begin
			count_reg <= count_next;
			tick_reg  <= tick_next;
		end
	end

	assign tick = tick_reg;

endmodule

`default_nettype wire

/* verilog/sird_top.sv */
// Interrupt enable, masked interrupt view and master rate divider registers
//
// What this block does
// - Writing ones to the enable-set register sets those enable bits; zeros leave them.
// - Reading the enable-set register returns all current enable bits.
// - Enables sit at their flag positions: assert 4, release 5, idle 8.
// - Assert enable lets any select going active raise the interrupt; resets to zero.
// - Release enable lets all selects going inactive raise the interrupt.
// - Idle enable at bit 8 lets a fully idle master raise the interrupt.
// - Writing ones to enable-clear bits 4, 5, 8 clears those enable bits.
// - Masked register is read-only, each bit is flag AND enable.
// - Masked bits sit at 4, 5 and 8 and read zero after reset.
// - Divider value in bits 15:0 divides the clock by value plus one.
// - Divider paces the serial clock only in master mode.
// - Divider resets to zero, giving the undivided clock rate.
// - Select-assert flag sets on any select going active, both modes; write one clears.
// - Select-release flag sets when all active selects go inactive; write one clears.
// - Master-idle flag is one when holding register empty and transmitter silent; resets one.
`timescale 1ns/1ps
`default_nettype none

module sird_top #(
	parameter int SEL_COUNT = 4
) (
	input  wire logic                       ref_clk,
	input  wire logic                       rst,
	input  wire sird_pkg::sird_bus_req_type bus_req,
	output var  logic [31:0]                bus_rdata,
	input  wire logic [SEL_COUNT-1:0]       sel_pin_n,
	input  wire sird_pkg::sird_engine_type  engine,
	output var  logic                       irq,
	output var  logic                       sclk_tick,
	output var  logic [15:0]                rate_prescale_value
);

	// ************************************************************
	// Functions
	// ************************************************************
	// True when the request addresses the given register
	function automatic logic addr_hit(
		input logic [sird_pkg::ADDR_W-1:0] addr,
		input logic [sird_pkg::ADDR_W-1:0] ofs
	);
		addr_hit = (addr == ofs);
	endfunction

	// Keep only implemented interrupt bit positions of a written word
	function automatic logic [31:0] impl_bits(
		input logic [31:0] word
	);
		impl_bits = word & sird_pkg::IMPL_MASK;
	endfunction

	// Pack the three flags into their word positions
	function automatic logic [31:0] pack_flags(
		input logic sel_assert,
		input logic sel_release,
		input logic master_quiet
	);
		logic [31:0] word;
		word                              = 32'h0000_0000;
		word[sird_pkg::BIT_SEL_ASSERT]    = sel_assert;
		word[sird_pkg::BIT_SEL_RELEASE]   = sel_release;
		word[sird_pkg::BIT_MASTER_QUIET]  = master_quiet;
		pack_flags = word;
	endfunction

	// ************************************************************
	// Select pin synchroniser
	// ************************************************************
	logic [SEL_COUNT-1:0] sel_meta_reg;
	logic [SEL_COUNT-1:0] sel_meta_next;
	logic [SEL_COUNT-1:0] sel_sync_reg;
	logic [SEL_COUNT-1:0] sel_sync_next;
	logic [SEL_COUNT-1:0] sel_prev_reg;
	logic [SEL_COUNT-1:0] sel_prev_next;

	// Two stages, then one more for edge detection on the clean copy
	always_comb begin
		sel_meta_next = sel_pin_n;
		sel_sync_next = sel_meta_reg;
		sel_prev_next = sel_sync_reg;
	end

	// Register the select chain, selects idle high
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			sel_meta_reg <= '1;
			sel_sync_reg <= '1;
			sel_prev_reg <= '1;
		end else begin
			sel_meta_reg <= sel_meta_next;
			sel_sync_reg <= sel_sync_next;
			sel_prev_reg <= sel_prev_next;
		end
	end

	// ************************************************************
	// Select events
	// ************************************************************
	logic assert_event;
	logic release_event;
	logic any_active_now;
	logic any_active_prev;

	// Events are seen in master and slave mode alike
	always_comb begin
		any_active_now  = |(~sel_sync_reg);
		any_active_prev = |(~sel_prev_reg);
		assert_event    = |(sel_prev_reg & ~sel_sync_reg); // Any line going active
		release_event   = any_active_prev && !any_active_now; // Last active line gone
	end

	// ************************************************************
	// Register state
	// ************************************************************
	logic [31:0] enable_reg;
	logic [31:0] enable_next;
	logic        assert_flag_reg;
	logic        assert_flag_next;
	logic        release_flag_reg;
	logic        release_flag_next;
	logic        quiet_flag_reg;
	logic        quiet_flag_next;
	logic [15:0] prescale_reg;
	logic [15:0] prescale_next;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic        irq_reg;
	logic        irq_next;

	// Views used by reads and the interrupt
	logic [31:0] flag_word;
	logic [31:0] masked_word;
	logic        wr_status;
	logic        wr_set;
	logic        wr_clear;
	logic        wr_prescale;
	logic [31:0] wbits;

	// Decode strobes and build the status and masked words
	always_comb begin
		wr_status   = bus_req.wr_stb && addr_hit(bus_req.addr, sird_pkg::OFS_STATUS);
		wr_set      = bus_req.wr_stb && addr_hit(bus_req.addr, sird_pkg::OFS_ENABLE_SET);
		wr_clear    = bus_req.wr_stb && addr_hit(bus_req.addr, sird_pkg::OFS_ENABLE_CLEAR);
		wr_prescale = bus_req.wr_stb && addr_hit(bus_req.addr, sird_pkg::OFS_PRESCALE);
		wbits       = impl_bits(bus_req.wdata); // Reserved write bits dropped
		flag_word   = pack_flags(assert_flag_reg, release_flag_reg, quiet_flag_reg);
		masked_word = flag_word & enable_reg; // Flag AND enable
	end

	// ************************************************************
	// Enable group
	// ************************************************************
	// Enable set, then clear; one strobe per cycle so they never meet
	always_comb begin
		enable_next = enable_reg;
		if (wr_set) begin
			enable_next = enable_reg | wbits; // Ones set, zeros keep
		end
		if (wr_clear) begin
			enable_next = enable_reg & ~wbits; // Ones clear, zeros keep
		end
	end

	// Register the enables, all off after reset
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			enable_reg <= sird_pkg::ENABLE_RST;
		end else begin
			enable_reg <= enable_next;
		end
	end

	// ************************************************************
	// Flag group
	// ************************************************************
	// Write one clears the event flags; a new event in the same cycle wins
	always_comb begin
		assert_flag_next  = assert_flag_reg;
		release_flag_next = release_flag_reg;
		if (wr_status && wbits[sird_pkg::BIT_SEL_ASSERT]) begin
			assert_flag_next = 1'h0;
		end
		if (wr_status && wbits[sird_pkg::BIT_SEL_RELEASE]) begin
			release_flag_next = 1'h0;
		end
		if (assert_event) begin
			assert_flag_next = 1'h1;
		end
		if (release_event) begin
			release_flag_next = 1'h1;
		end
		// Idle when nothing is held for sending and nothing is on the wire
		quiet_flag_next = engine.tx_hold_empty && !engine.tx_busy;
	end

	// Register the flags; the idle flag starts set
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			assert_flag_reg  <= sird_pkg::EVENT_FLAG_RST;
			release_flag_reg <= sird_pkg::EVENT_FLAG_RST;
			quiet_flag_reg   <= sird_pkg::QUIET_FLAG_RST;
		end else begin
			assert_flag_reg  <= assert_flag_next;
			release_flag_reg <= release_flag_next;
			quiet_flag_reg   <= quiet_flag_next;
		end
	end

	// ************************************************************
	// Divider value group
	// ************************************************************
	// Divider value, upper bits of the word are not stored
	always_comb begin
		prescale_next = prescale_reg;
		if (wr_prescale) begin
			prescale_next = bus_req.wdata[sird_pkg::PRESCALE_W-1:0];
		end
	end

	// Register the divider value, zero after reset
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			prescale_reg <= sird_pkg::PRESCALE_RST;
		end else begin
			prescale_reg <= prescale_next;
		end
	end

	// ************************************************************
	// Read group
	// ************************************************************
	// Read data stand only in the cycle after the strobe
	always_comb begin
		rdata_next = sird_pkg::RDATA_RST;
		if (bus_req.rd_stb) begin
			unique case (bus_req.addr)
				sird_pkg::OFS_STATUS: begin
					rdata_next = flag_word;
				end
				sird_pkg::OFS_ENABLE_SET: begin
					rdata_next = enable_reg; // Whole enable set
				end
				sird_pkg::OFS_ENABLE_CLEAR: begin
					rdata_next = 32'h0000_0000; // Write-only
				end
				sird_pkg::OFS_PRESCALE: begin
					rdata_next = {16'h0000, prescale_reg}; // Last written value
				end
				sird_pkg::OFS_MASKED: begin
					rdata_next = masked_word; // Read-only view at 4, 5, 8
				end
				default: begin
					rdata_next = 32'h0000_0000;
				end
			endcase
		end
	end

	// Register the read data, zero outside a read slot
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rdata_reg <= sird_pkg::RDATA_RST;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	// ************************************************************
	// Interrupt group
	// ************************************************************
	// Single level request from any masked bit
	always_comb begin
		irq_next = |masked_word;
	end

	// Register the request, low in reset
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			irq_reg <= 1'h0;
		end else begin
			irq_reg <= irq_next; // Gated per source
		end
	end

	// ************************************************************
	// Master rate divider
	// ************************************************************
	// Runs only while the engine is master; slave clocking comes from the pin
	sird_rate_div #(
		.DIV_W     (sird_pkg::PRESCALE_W)
	) u_rate_div (
		.ref_clk   (ref_clk),
		.rst       (rst),
		.run       (engine.master_mode),
		.div_value (prescale_reg),
		.tick      (sclk_tick)
	);

	// ************************************************************
	// Outputs
	// ************************************************************
	assign bus_rdata           = rdata_reg;
	assign irq                 = irq_reg;
	assign rate_prescale_value = prescale_reg;

endmodule

`default_nettype wire

/* dv/sird_far_side.sv */
// Behavioural far side: select lines and serial engine state
`timescale 1ns/1ps
`default_nettype none

module sird_far_side #(
	parameter int SEL_COUNT = 4
) (
	input  wire logic                      ref_clk,
	input  wire logic [SEL_COUNT-1:0]      want_sel,
	input  wire logic                      want_master,
	input  wire logic                      want_busy,
	output var  logic [SEL_COUNT-1:0]      sel_pin_n,
	output var  sird_pkg::sird_engine_type engine
);
	// Selects idle high (pulled up), engine idle in slave mode; lines then move just after an edge
	initial begin
		sel_pin_n = '1;
		engine    = '{master_mode: 1'h0, tx_hold_empty: 1'h1, tx_busy: 1'h0};
		forever begin
			@(posedge ref_clk);
			sel_pin_n            <= ~want_sel;
			engine.master_mode   <= want_master;
			engine.tx_hold_empty <= !want_busy;
			engine.tx_busy       <= want_busy;
		end
	end
endmodule

`default_nettype wire

/* dv/sird_monitor.sv */
// Checker of the register bus, interrupt and rate divider ports
`timescale 1ns/1ps
`default_nettype none

module sird_monitor #(
	parameter int SEL_COUNT = 4
) (
	input  wire logic                       ref_clk,
	input  wire logic                       rst,
	input  wire sird_pkg::sird_bus_req_type bus_req,
	input  wire logic [31:0]                bus_rdata,
	input  wire logic [SEL_COUNT-1:0]       sel_pin_n,
	input  wire sird_pkg::sird_engine_type  engine,
	input  wire logic                       irq,
	input  wire logic                       sclk_tick,
	input  wire logic [15:0]                rate_prescale_value
);
	// All checks on the one clock, quiet in reset
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	a_rdata_idle: assert property (!$past(bus_req.rd_stb) |-> bus_rdata == 32'h0)
		else $error("read data outside read slot");
	a_clear_zero: assert property (bus_req.rd_stb && bus_req.addr == sird_pkg::OFS_ENABLE_CLEAR
		|=> bus_rdata == 32'h0) else $error("enable clear read not zero");
	a_reserved_zero: assert property (bus_req.rd_stb && bus_req.addr != sird_pkg::OFS_PRESCALE
		|=> (bus_rdata & ~sird_pkg::IMPL_MASK) == 32'h0) else $error("reserved bits not zero");
	a_prescale_store: assert property (bus_req.wr_stb && bus_req.addr == sird_pkg::OFS_PRESCALE
		|=> rate_prescale_value == $past(bus_req.wdata[15:0])) else $error("divider not stored");
	a_slave_quiet: assert property (!$past(engine.master_mode) |-> !sclk_tick)
		else $error("tick outside master mode");
	a_undivided_rate: assert property (!$past(rst) && $past(engine.master_mode)
		&& $past(rate_prescale_value) == 16'h0 |-> sclk_tick) else $error("divide by one missing tick");
	a_period_three: assert property ((sclk_tick && engine.master_mode && rate_prescale_value == 16'h0002)
		##1 (engine.master_mode && rate_prescale_value == 16'h0002)[*3]
		|-> sclk_tick && !$past(sclk_tick) && !$past(sclk_tick, 2)) else $error("divide by three wrong");
	a_clear_quiets: assert property ((bus_req.wr_stb && bus_req.addr == sird_pkg::OFS_ENABLE_CLEAR
		&& bus_req.wdata == 32'h130) ##1 !(bus_req.wr_stb && bus_req.addr == sird_pkg::OFS_ENABLE_SET)
		|=> !irq) else $error("irq after all enables cleared");
endmodule

bind sird_top sird_monitor #(.SEL_COUNT(SEL_COUNT)) u_mon (.ref_clk(ref_clk), .rst(rst), .bus_req(bus_req),
	.bus_rdata(bus_rdata), .sel_pin_n(sel_pin_n), .engine(engine), .irq(irq), .sclk_tick(sclk_tick),
	.rate_prescale_value(rate_prescale_value));

`default_nettype wire

/* dv/sird_tb_top.sv */
// Self-checking bench of the interrupt enable and rate divider registers
`timescale 1ns/1ps
`default_nettype none

module sird_tb_top;
	logic                       ref_clk = 1'b0;
	logic                       rst = 1'b1;
	sird_pkg::sird_bus_req_type bus_req = '0;
	logic [31:0]                bus_rdata;
	logic [3:0]                 sel_pin_n;
	sird_pkg::sird_engine_type  engine;
	logic                       irq;
	logic                       sclk_tick;
	logic [15:0]                rate_prescale_value;
	logic [3:0]                 want_sel = 4'h0;
	logic                       want_master = 1'b0;
	logic                       want_busy = 1'b0;
	logic [31:0]                acc = 32'h0;
	logic [31:0]                bits [3] = '{32'h010, 32'h020, 32'h100};
	int                         n_fail = 0;
	int                         samples_checked = 0;
	int                         cycles = 0;
	int                         n;

	sird_top #(.SEL_COUNT(4)) u_dut (.ref_clk(ref_clk), .rst(rst), .bus_req(bus_req), .bus_rdata(bus_rdata),
		.sel_pin_n(sel_pin_n), .engine(engine), .irq(irq), .sclk_tick(sclk_tick),
		.rate_prescale_value(rate_prescale_value));
	sird_far_side #(.SEL_COUNT(4)) u_far (.ref_clk(ref_clk), .want_sel(want_sel), .want_master(want_master),
		.want_busy(want_busy), .sel_pin_n(sel_pin_n), .engine(engine));

	// Clock at 40 MHz
	initial begin
		forever #12.5 ref_clk = ~ref_clk;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		samples_checked++;
		if (seen !== exp) begin
			$display("wrong value %s expected %h seen %h", what, exp, seen);
			n_fail++;
		end
	endtask

	// Bus cycles; reserved bits always written as zero
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		bus_req <= '{addr: a, wdata: d, wr_stb: 1'b1, rd_stb: 1'b0}; // Callers keep reserved bits zero
		@(posedge ref_clk);
		bus_req.wr_stb <= 1'b0;
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string what);
		@(posedge ref_clk);
		bus_req <= '{addr: a, wdata: 32'h0, wr_stb: 1'b0, rd_stb: 1'b1};
		@(posedge ref_clk);
		bus_req.rd_stb <= 1'b0;
		#1 check(bus_rdata, exp, what);
	endtask

	task automatic wt(input int k);
		repeat (k) @(posedge ref_clk);
		#1;
	endtask

	// Counts edges until the next serial clock tick
	task automatic gap;
		n = 0;
		do begin
			@(posedge ref_clk);
			#1 n++;
		end while (!sclk_tick && n < 70000);
	endtask

	task automatic report_and_stop;
		if (n_fail == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Hang guard
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 80000) begin
			n_fail++;
			report_and_stop;
		end
	end

	// Main sequence
	initial begin
		repeat (10) @(posedge ref_clk);
		rst <= 1'b0;
		rd(sird_pkg::OFS_ENABLE_SET, 32'h0, "en");
		rd(sird_pkg::OFS_MASKED, 32'h0, "masked");
		rd(sird_pkg::OFS_PRESCALE, 32'h0, "div");
		rd(12'h500, 32'h0, "unmapped");
		check({31'h0, irq}, 32'h0, "irq");
		// Set one enable at a time, a zero write keeps them
		foreach (bits[i]) begin
			wr(sird_pkg::OFS_ENABLE_SET, bits[i]);
			wr(sird_pkg::OFS_ENABLE_SET, 32'h0);
			acc = acc | bits[i];
			rd(sird_pkg::OFS_ENABLE_SET, acc, "en");
		end
		// Idle engine in slave mode raises the interrupt; masked view ignores writes
		wt(3);
		rd(sird_pkg::OFS_MASKED, 32'h100, "masked");
		check({31'h0, irq}, 32'h1, "irq");
		wr(sird_pkg::OFS_MASKED, 32'h0);
		rd(sird_pkg::OFS_MASKED, 32'h100, "masked");
		want_busy <= 1'b1;
		wt(4);
		rd(sird_pkg::OFS_MASKED, 32'h0, "masked");
		check({31'h0, irq}, 32'h0, "irq");
		want_busy <= 1'b0;
		foreach (bits[i]) begin
			wr(sird_pkg::OFS_ENABLE_CLEAR, bits[i]);
			acc = acc & ~bits[i];
			rd(sird_pkg::OFS_ENABLE_SET, acc, "en");
			rd(sird_pkg::OFS_ENABLE_CLEAR, 32'h0, "clr");
		end
		// Select assert and release events
		wr(sird_pkg::OFS_ENABLE_SET, 32'h30);
		want_sel <= 4'h1;
		wt(6);
		rd(sird_pkg::OFS_MASKED, 32'h10, "masked");
		check({31'h0, irq}, 32'h1, "irq");
		wr(sird_pkg::OFS_STATUS, 32'h10);
		want_sel <= 4'h3;
		wt(6);
		want_sel <= 4'h2;
		wt(6);
		rd(sird_pkg::OFS_MASKED, 32'h10, "masked");
		wr(sird_pkg::OFS_STATUS, 32'h10);
		rd(sird_pkg::OFS_MASKED, 32'h0, "masked");
		want_sel <= 4'h0;
		wt(6);
		rd(sird_pkg::OFS_MASKED, 32'h20, "masked");
		check({31'h0, irq}, 32'h1, "irq");
		wr(sird_pkg::OFS_ENABLE_CLEAR, 32'h130);
		want_sel <= 4'h1;
		wt(6);
		rd(sird_pkg::OFS_MASKED, 32'h0, "masked");
		check({31'h0, irq}, 32'h0, "irq");
		rd(sird_pkg::OFS_STATUS, 32'h130, "status");
		wr(sird_pkg::OFS_STATUS, 32'h30);
		rd(sird_pkg::OFS_STATUS, 32'h100, "status");
		// Divider: slowest rate, then divide by three and by one
		wr(sird_pkg::OFS_PRESCALE, 32'hFFFF);
		rd(sird_pkg::OFS_PRESCALE, 32'hFFFF, "div");
		check({16'h0, rate_prescale_value}, 32'h0000_FFFF, "div out");
		want_master <= 1'b1;
		gap;
		check({31'h0, n >= 65536 && n <= 65538}, 32'h1, "slow");
		wr(sird_pkg::OFS_PRESCALE, 32'h2);
		gap;
		gap;
		check(n, 32'h3, "gap2");
		gap;
		check(n, 32'h3, "gap2");
		check({16'h0, rate_prescale_value}, 32'h0000_0002, "div out");
		wr(sird_pkg::OFS_PRESCALE, 32'h0);
		gap;
		gap;
		check(n, 32'h1, "gap0");
		// Select events are seen in master mode as well
		want_sel <= 4'h0;
		wt(6);
		rd(sird_pkg::OFS_STATUS, 32'h120, "status");
		want_sel <= 4'h1;
		wt(6);
		rd(sird_pkg::OFS_STATUS, 32'h130, "status");
		want_master <= 1'b0;
		wt(2);
		n = 0;
		repeat (20) begin
			@(posedge ref_clk);
			#1 n += sclk_tick;
		end
		check(n, 32'h0, "slave");
		report_and_stop;
	end
endmodule

`default_nettype wire
